// ### src/erhf_pkg.sv
// constants and state types for the early-receive and group hash filter
package erhf_pkg;

  // register indices; the bus byte address is the index times four
  localparam logic [7:0]  IDX_HASH0     = 8'h00;
  localparam logic [7:0]  IDX_HASH1     = 8'h02;
  localparam logic [7:0]  IDX_HASH2     = 8'h04;
  localparam logic [7:0]  IDX_HASH3     = 8'h06;
  localparam logic [7:0]  IDX_ERX_CFG   = 8'h0a;
  localparam logic [7:0]  IDX_RX_CTRL   = 8'h0c;
  localparam logic [7:0]  IDX_INT_STAT  = 8'h0e;
  localparam logic [7:0]  IDX_INT_MASK  = 8'h10;
  localparam logic [7:0]  IDX_FRAME_CNT = 8'h12;
  localparam int          WORD_BYTES    = 4;

  // early_receive_config fields and reset values
  localparam int          ERX_EN_BIT    = 7;
  localparam int          ERX_TH_MSB    = 4;
  localparam int          ERX_TH_W      = 5;
  localparam logic [4:0]  ERX_TH_RESET  = 5'h1f;
  localparam logic        ERX_EN_RESET  = 1'b0;
  localparam int          TH_UNIT_LOG2  = 6;

  // rx_control_register fields
  localparam int          RXC_ALL_BIT   = 0;
  localparam int          RXC_GRP_BIT   = 1;

  // interrupt status / mask bits
  localparam int          INT_W         = 2;
  localparam int          INT_EARLY_RX  = 0;
  localparam int          INT_GRP_DROP  = 1;

  // hash table geometry and crc
  localparam int          HASH_WORDS    = 4;
  localparam int          HASH_W        = 16;
  localparam int          HASH_IDX_W    = 6;
  localparam int          DA_BYTES      = 6;
  localparam logic [31:0] CRC_INIT      = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY_REFL = 32'hedb8_8320;
  localparam int          CNT_W         = 12;
  localparam logic [15:0] REG_RESET     = 16'h0000;

  typedef struct packed {
    logic [31:0]           crc;
    logic [2:0]            byteNum;
    logic                  isGroup;
    logic [HASH_IDX_W-1:0] index;
    logic                  done;
  } erhf_hash_t;

  typedef struct packed {
    logic [HASH_WORDS-1:0][HASH_W-1:0] hash;
    logic                  erEnable;
    logic [ERX_TH_W-1:0]   erThresh;
    logic                  rxAll;
    logic                  rxAllGroup;
    logic [INT_W-1:0]      intStatus;
    logic [INT_W-1:0]      intMask;
    logic [CNT_W-1:0]      byteCnt;
    logic                  erHit;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  filtValid;
    logic                  filtAccept;
    logic                  irq;
  } erhf_top_t;

endpackage

// ### src/erhf_hash_if.sv
// link between the receive filter and its destination-address hash unit
`timescale 1ns/1ps
`default_nettype none
interface erhf_hash_if;
  logic                             byteValid;
  logic                             byteFirst;
  logic [7:0]                       byteData;
  logic                             hashDone;
  logic                             isGroup;
  logic [erhf_pkg::HASH_IDX_W-1:0]  hashIndex;

  modport filter (output byteValid, output byteFirst, output byteData,
                  input hashDone, input isGroup, input hashIndex);
  modport hasher (input byteValid, input byteFirst, input byteData,
                  output hashDone, output isGroup, output hashIndex);
endinterface
`default_nettype wire

// ### src/erhf_da_hash.sv
// crc-32 over the destination address, yielding the six-bit table index
`timescale 1ns/1ps
`default_nettype none
module erhf_da_hash (
  input  wire logic  sys_clk,
  input  wire logic  rst,
  erhf_hash_if.hasher hif
);
  erhf_pkg::erhf_hash_t q;
  erhf_pkg::erhf_hash_t d;
  logic [31:0]          c;
  logic [2:0]           num;

  // one byte per cycle, bits taken least significant first as on the wire
  always_comb begin
    d = q;
    c = q.crc;
    num = q.byteNum;
    d.done = 1'b0;
    if (hif.byteValid) begin
      if (hif.byteFirst) begin
        c = erhf_pkg::CRC_INIT;
        num = 3'h0;
        d.isGroup = hif.byteData[0];
      end
      if (num < 3'(erhf_pkg::DA_BYTES)) begin
        // reflected ethernet crc-32 over all 48 address bits
        for (int i = 0; i < 8; i++) begin
          if (c[0] ^ hif.byteData[i]) begin
            c = (c >> 1) ^ erhf_pkg::CRC_POLY_REFL;
          end else begin
            c = c >> 1;
          end
        end
        d.crc = c;
        d.byteNum = num + 3'h1;
        if (num == 3'(erhf_pkg::DA_BYTES - 1)) begin
          d.done = 1'b1;
          d.index = c[31:26];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.byteNum <= 3'(erhf_pkg::DA_BYTES);
    end else begin
      q <= d;
    end
  end

  assign hif.hashDone  = q.done;
  assign hif.isGroup   = q.isGroup;
  assign hif.hashIndex = q.index;
endmodule
`default_nettype wire

// ### src/erhf_rx_filter.sv
// early-receive threshold and group hash filter with apb registers
//
// Functional notes
// - enable bit 7 turns early receive on
// - threshold bits 4:0 in 64-byte units
// - status sets when stored bytes exceed threshold
// - interrupt raised only when its source enabled
// - reset: disabled, threshold all ones, reserved zero
// - sixty-four bit table in four words
// - index is six crc msbs over address
// - top index bits pick word, low bits bit
// - set table bit accepts group frame
// - clear table bit drops group frame
// - receive-all or receive-all-group accepts all groups
// - words 0 and 1 at 0x00, 0x02, rw, zero
// - words 2 and 3 at 0x04, 0x06
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module erhf_rx_filter (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receive byte stream as it is written to buffer memory
  input  wire logic        rxValid,
  input  wire logic        rxFirst,
  input  wire logic [7:0]  rxData,
  // per-frame filter verdict
  output logic             filtValid,
  output logic             filtAccept,
  // early-receive status of the frame now arriving
  output logic             earlyRxStatus,
  output logic             irq
);
  erhf_pkg::erhf_top_t q;
  erhf_pkg::erhf_top_t d;

  erhf_hash_if hif ();

  erhf_da_hash u_hash (
    .sys_clk (sys_clk),
    .rst     (rst),
    .hif     (hif)
  );

  // stream bytes straight into the hasher; it ignores bytes past the address
  assign hif.byteValid = rxValid;
  assign hif.byteFirst = rxFirst;
  assign hif.byteData  = rxData;

  // byte addresses derived from the register indices
  localparam logic [7:0] A_HASH0 = 8'(erhf_pkg::IDX_HASH0 *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_HASH1 = 8'(erhf_pkg::IDX_HASH1 *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_HASH2 = 8'(erhf_pkg::IDX_HASH2 *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_HASH3 = 8'(erhf_pkg::IDX_HASH3 *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_ERX   = 8'(erhf_pkg::IDX_ERX_CFG *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_RXC   = 8'(erhf_pkg::IDX_RX_CTRL *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_ISTAT = 8'(erhf_pkg::IDX_INT_STAT *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_IMASK = 8'(erhf_pkg::IDX_INT_MASK *
                                      erhf_pkg::WORD_BYTES);
  localparam logic [7:0] A_FCNT  = 8'(erhf_pkg::IDX_FRAME_CNT *
                                      erhf_pkg::WORD_BYTES);

  logic                            setup;
  logic                            wrAcc;
  logic [31:0]                     rdVal;
  logic                            hit;
  logic [15:0]                     wMask;
  logic [15:0]                     wVal;
  logic [erhf_pkg::INT_W-1:0]      evSet;
  logic [erhf_pkg::INT_W-1:0]      evClr;
  logic [erhf_pkg::CNT_W-1:0]      cntNext;
  logic [erhf_pkg::CNT_W-1:0]      thBytes;
  logic [1:0]                      wordSel;
  logic [3:0]                      bitSel;
  logic                            tableBit;
  logic                            accept;

  // read mux and address decode, evaluated in the setup phase
  always_comb begin
    rdVal = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == A_HASH0) begin
      rdVal[15:0] = q.hash[0];
    end else if (paddr == A_HASH1) begin
      rdVal[15:0] = q.hash[1];
    end else if (paddr == A_HASH2) begin
      rdVal[15:0] = q.hash[2];
    end else if (paddr == A_HASH3) begin
      rdVal[15:0] = q.hash[3];
    end else if (paddr == A_ERX) begin
      // reserved bits 15:8 and 6:5 read as zero
      rdVal[erhf_pkg::ERX_EN_BIT] = q.erEnable;
      rdVal[erhf_pkg::ERX_TH_MSB:0] = q.erThresh;
    end else if (paddr == A_RXC) begin
      rdVal[erhf_pkg::RXC_ALL_BIT] = q.rxAll;
      rdVal[erhf_pkg::RXC_GRP_BIT] = q.rxAllGroup;
    end else if (paddr == A_ISTAT) begin
      rdVal[erhf_pkg::INT_W-1:0] = q.intStatus;
    end else if (paddr == A_IMASK) begin
      rdVal[erhf_pkg::INT_W-1:0] = q.intMask;
    end else if (paddr == A_FCNT) begin
      rdVal[erhf_pkg::CNT_W-1:0] = q.byteCnt;
    end else begin
      hit = 1'b0;
    end
  end

  // write strobes: two byte lanes carry the 16-bit registers
  always_comb begin
    setup = psel && !penable;
    wrAcc = psel && penable && q.pready && pwrite;
    wMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wVal = pwdata[15:0];
  end

  // table lookup: upper index bits pick the word, lower the bit
  always_comb begin
    wordSel = hif.hashIndex[5:4];
    bitSel = hif.hashIndex[3:0];
    tableBit = q.hash[wordSel][bitSel];
    // individual frames pass untouched; only group frames are filtered
    accept = !hif.isGroup || tableBit || q.rxAll || q.rxAllGroup;
  end

  // byte count of the frame now arriving and threshold in bytes
  always_comb begin
    thBytes = erhf_pkg::CNT_W'(q.erThresh) << erhf_pkg::TH_UNIT_LOG2;
    if (rxFirst) begin
      cntNext = erhf_pkg::CNT_W'(1);
    end else if (&q.byteCnt) begin
      // saturate so a giant frame never wraps below the threshold
      cntNext = q.byteCnt;
    end else begin
      cntNext = q.byteCnt + erhf_pkg::CNT_W'(1);
    end
  end

  // next-state of the whole block
  always_comb begin
    d = q;
    evSet = '0;
    evClr = '0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.filtValid = 1'b0;

    // apb: answer one cycle into the access phase
    if (setup) begin
      d.pready = 1'b1;
      d.pslverr = !hit;
      d.prdata = pwrite ? 32'h0000_0000 : rdVal;
    end

    if (wrAcc && hit) begin
      if (paddr == A_HASH0) begin
        d.hash[0] = (q.hash[0] & ~wMask) | (wVal & wMask);
      end else if (paddr == A_HASH1) begin
        d.hash[1] = (q.hash[1] & ~wMask) | (wVal & wMask);
      end else if (paddr == A_HASH2) begin
        d.hash[2] = (q.hash[2] & ~wMask) | (wVal & wMask);
      end else if (paddr == A_HASH3) begin
        d.hash[3] = (q.hash[3] & ~wMask) | (wVal & wMask);
      end else if (paddr == A_ERX) begin
        if (pstrb[0]) begin
          d.erEnable = pwdata[erhf_pkg::ERX_EN_BIT];
          d.erThresh = pwdata[erhf_pkg::ERX_TH_MSB:0];
        end
      end else if (paddr == A_RXC) begin
        if (pstrb[0]) begin
          d.rxAll = pwdata[erhf_pkg::RXC_ALL_BIT];
          d.rxAllGroup = pwdata[erhf_pkg::RXC_GRP_BIT];
        end
      end else if (paddr == A_ISTAT) begin
        if (pstrb[0]) begin
          evClr = pwdata[erhf_pkg::INT_W-1:0];
        end
      end else if (paddr == A_IMASK) begin
        if (pstrb[0]) begin
          d.intMask = pwdata[erhf_pkg::INT_W-1:0];
        end
      end
    end

    // early receive: count stored bytes, flag once per frame
    if (rxValid) begin
      d.byteCnt = cntNext;
      if (rxFirst) begin
        d.erHit = 1'b0;
      end
      // a zero threshold while enabled is left to the host to avoid
      if (q.erEnable && (cntNext > thBytes) &&
          (rxFirst || !q.erHit)) begin
        d.erHit = 1'b1;
        evSet[erhf_pkg::INT_EARLY_RX] = 1'b1;
      end
    end

    // verdict one cycle after the hasher's done pulse
    if (hif.hashDone) begin
      d.filtValid = 1'b1;
      d.filtAccept = accept;
      if (!accept) begin
        evSet[erhf_pkg::INT_GRP_DROP] = 1'b1;
      end
    end

    // set wins over a same-cycle write-one-to-clear
    d.intStatus = (q.intStatus & ~evClr) | evSet;
    d.irq = |(d.intStatus & d.intMask);
  end

  // all state in one register; reset values as documented
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.erEnable <= erhf_pkg::ERX_EN_RESET;
      q.erThresh <= erhf_pkg::ERX_TH_RESET;
      q.hash <= {erhf_pkg::HASH_WORDS{erhf_pkg::REG_RESET}};
    end else begin
      q <= d;
    end
  end

  // every output is a flip-flop of the state register
  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign filtValid     = q.filtValid;
  assign filtAccept    = q.filtAccept;
  assign earlyRxStatus = q.erHit;
  assign irq           = q.irq;
endmodule
`default_nettype wire

// ### tb/erhf_rx_filter_monitor.sv
// port assertions for the early-receive and group hash filter
`timescale 1ns/1ps
`default_nettype none
module erhf_rx_filter_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rxValid,
  input wire logic       rxFirst,
  input wire logic [7:0] rxData,
  input wire logic       filtValid,
  input wire logic       filtAccept,
  input wire logic       earlyRxStatus
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // six address bytes, the first one opening a frame
  sequence s_addr;
    rxValid && rxFirst ##1 (rxValid && !rxFirst) [*5];
  endsequence
  // same, with the group bit of the first byte clear
  sequence s_ind_addr;
    rxValid && rxFirst && !rxData[0] ##1 (rxValid && !rxFirst) [*5];
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // the hasher flags done one edge after byte six; the verdict is one later
  chk_verdict_after_addr: assert property (s_addr |-> ##2 filtValid)
    else $error("no verdict after address");
  chk_verdict_pulse: assert property (filtValid |=> !filtValid)
    else $error("verdict pulse too long");
  chk_individual_accept: assert property (
    s_ind_addr |-> ##2 filtAccept)
    else $error("individual frame dropped");
  chk_early_hold: assert property (
    earlyRxStatus && !(rxValid && rxFirst) |=> earlyRxStatus)
    else $error("early status dropped mid frame");
  chk_early_clear: assert property (
    rxValid && rxFirst |=> !earlyRxStatus)
    else $error("early status kept into new frame");
  chk_early_cause: assert property (
    $rose(earlyRxStatus) |-> $past(rxValid))
    else $error("early status rose without a byte");
endmodule
bind erhf_rx_filter erhf_rx_filter_monitor erhf_rx_filter_monitor_i (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
  .rxFirst(rxFirst), .rxData(rxData), .filtValid(filtValid),
  .filtAccept(filtAccept), .earlyRxStatus(earlyRxStatus));
`default_nettype wire

// ### tb/erhf_rx_src.sv
// receive byte source standing in for the mac receive path
`timescale 1ns/1ps
`default_nettype none
module erhf_rx_src (
  input  wire logic       sys_clk,
  output var  logic       rxValid,
  output var  logic       rxFirst,
  output var  logic [7:0] rxData
);
  initial begin
    rxValid = 1'h0;
    rxFirst = 1'h0;
    rxData  = 8'h00;
  end
  // one byte per cycle, never stalled; byte i below 6 is address byte i
  task automatic send(input logic [47:0] da, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      rxValid <= 1'h1;
      rxFirst <= (i == 0);
      rxData  <= (i < 6) ? da[8*(i%6) +: 8] : 8'(i);
    end
    @(posedge sys_clk);
    rxValid <= 1'h0;
    rxFirst <= 1'h0;
    rxData  <= ~rxData;  // idle line must not look like the last byte
  endtask
endmodule
`default_nettype wire

// ### tb/erhf_rx_filter_tb.sv
// self-checking bench for the early-receive and group hash filter
`timescale 1ns/1ps
`default_nettype none
module erhf_rx_filter_tb;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        rxValid, rxFirst, filtValid, filtAccept, earlyRxStatus, irq;
  logic        err;
  logic [7:0]  paddr, rxData;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          mismatches, compares;
  localparam logic [7:0] HW[4] = '{erhf_pkg::IDX_HASH0,
    erhf_pkg::IDX_HASH1, erhf_pkg::IDX_HASH2, erhf_pkg::IDX_HASH3};
  erhf_rx_filter erhf_rx_filter_i (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxValid(rxValid), .rxFirst(rxFirst),
    .rxData(rxData), .filtValid(filtValid), .filtAccept(filtAccept),
    .earlyRxStatus(earlyRxStatus), .irq(irq));
  erhf_rx_src erhf_rx_src_i (.sys_clk(sys_clk), .rxValid(rxValid),
    .rxFirst(rxFirst), .rxData(rxData));
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] adr(input logic [7:0] idx);
    return 8'(idx * erhf_pkg::WORD_BYTES);
  endfunction
  // reflected crc over the address, first byte first, lsb first
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = erhf_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = (c[0] ^ da[i]) ? (c >> 1) ^ erhf_pkg::CRC_POLY_REFL : c >> 1;
    return c[31:26];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait on pready is bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk(n < 16, 1'h1);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'h0, adr(idx), 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic t_regs;
    for (int k = 0; k < 4; k++) begin
      rchk(HW[k], 32'h0000_0000);
      apb(1'h1, adr(HW[k]), 32'hffff_a5c0 + k);
      rchk(HW[k], 32'h0000_a5c0 + k);
      apb(1'h1, adr(HW[k]), 32'h0000_0000);
    end
    // low byte lane only: the upper byte of the word must keep its zeros
    pstrb <= 4'h1;
    apb(1'h1, adr(HW[0]), 32'h0000_ffff);
    rchk(HW[0], 32'h0000_00ff);
    pstrb <= 4'hf;
    apb(1'h1, adr(HW[0]), 32'h0000_0000);
    rchk(erhf_pkg::IDX_ERX_CFG, 32'h0000_001f);
    apb(1'h1, adr(erhf_pkg::IDX_ERX_CFG), 32'h0000_ffff);
    rchk(erhf_pkg::IDX_ERX_CFG, 32'h0000_009f);
    apb(1'h1, 8'hfc, 32'h0000_ffff);
    chk(err, 1'h1);
    rchk(8'h3f, 32'h0000_0000);
    chk(err, 1'h1);
    $display("t_regs done");
  endtask
  // frame, then the verdict it left behind
  task automatic frame(input logic [47:0] da, input logic exp);
    erhf_rx_src_i.send(da, 8);
    chk(filtAccept, exp);
  endtask
  task automatic t_hash;
    logic [47:0] da;
    logic [5:0]  ix;
    da = 48'h0000_0000_0001;  // group bit set
    for (int w = 0; w < 4; w++) begin
      do begin
        da[15:8]++;
        ix = hidx(da);
      end while (ix[5:4] != w);
      frame(da, 1'h0);
      frame(48'h0000_0000_0000, 1'h1);
      apb(1'h1, adr(HW[w]), 32'h0000_0001 << (ix[3:0] ^ 4'h1));
      frame(da, 1'h0);
      apb(1'h1, adr(HW[w]), 32'h0000_0001 << ix[3:0]);
      frame(da, 1'h1);
      apb(1'h1, adr(HW[w]), 32'h0000_0000);
    end
    for (int b = 0; b < 2; b++) begin
      frame(da, 1'h0);
      apb(1'h1, adr(erhf_pkg::IDX_RX_CTRL), 32'h0000_0001 << b);
      frame(da, 1'h1);
      apb(1'h1, adr(erhf_pkg::IDX_RX_CTRL), 32'h0000_0000);
    end
    $display("t_hash done");
  endtask
  task automatic t_early;
    // threshold, enable, frame length, status expected
    int tb[7][4] = '{'{1, 1, 64, 0}, '{1, 1, 65, 1}, '{2, 1, 128, 0},
      '{2, 1, 129, 1}, '{1, 0, 200, 0}, '{31, 1, 1984, 0}, '{31, 1, 1985, 1}};
    apb(1'h1, adr(erhf_pkg::IDX_INT_STAT), 32'h0000_0003);
    for (int t = 0; t < 7; t++) begin
      // threshold never zero while enabled
      apb(1'h1, adr(erhf_pkg::IDX_ERX_CFG),
          (tb[t][1] << erhf_pkg::ERX_EN_BIT) | tb[t][0]);
      erhf_rx_src_i.send(48'h0000_0000_0000, tb[t][2]);
      // the last byte is taken on the edge send returns at; status follows
      @(posedge sys_clk);
      chk(earlyRxStatus, tb[t][3]);
      rchk(erhf_pkg::IDX_INT_STAT, tb[t][3]);
      chk(irq, 1'h0);
      apb(1'h1, adr(erhf_pkg::IDX_INT_STAT), 32'h0000_0001);
    end
    // threshold of one unit, so the 66-byte frame raises the event
    apb(1'h1, adr(erhf_pkg::IDX_ERX_CFG), 32'h0000_0081);
    erhf_rx_src_i.send(48'h0000_0000_0000, 66);
    rchk(erhf_pkg::IDX_FRAME_CNT, 32'h0000_0042);
    apb(1'h1, adr(erhf_pkg::IDX_INT_MASK), 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'h1);
    apb(1'h1, adr(erhf_pkg::IDX_INT_STAT), 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'h0);
    $display("t_early done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog: well beyond the few thousand cycles the tests need
  initial begin
    #(20 * 40000);
    mismatches++;
    close_out();
  end
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    t_regs();
    t_hash();
    t_early();
    close_out();
  end
endmodule
`default_nettype wire
